// ---- hw/door_access_pkg.sv ----
// shared constants and types of the door access controller
package door_access_pkg;

  localparam int CLK_FREQ_MHZ = 250;

  // largest frame the reader may send is one bit below this
  localparam int FRAME_LIMIT_BITS = 128;
  localparam int FRAME_MAX_BITS = FRAME_LIMIT_BITS - 1;
  localparam int BIT_COUNT_W = 8;
  localparam int TIMER_W = 32;

  // quiet gap on both data lines that ends a frame
  localparam int INTERBIT_TIMEOUT_US = 20000;
  localparam int INTERBIT_TIMEOUT_CYCLES = INTERBIT_TIMEOUT_US * CLK_FREQ_MHZ;

  // length of the reader led pulse after an accepted card
  localparam int LED_PULSE_MS = 200;
  localparam int LED_PULSE_CYCLES = LED_PULSE_MS * 1000 * CLK_FREQ_MHZ;

  // synchroniser lanes, one per pin
  localparam int PIN_D0 = 0;
  localparam int PIN_D1 = 1;
  localparam int PIN_CARD = 2;
  localparam int PIN_EXIT = 3;
  localparam int PIN_AUX = 4;
  localparam int PIN_DOOR = 5;
  localparam int PIN_XTAMP = 6;
  localparam int PIN_OBTAMP = 7;
  localparam int PIN_COUNT = 8;

  // data lines idle high, contacts read open
  localparam logic [PIN_COUNT-1:0] PIN_RESET_VAL = 8'h03;

  localparam logic [TIMER_W-1:0] TIMER_ZERO = 32'h00000000;
  localparam logic [BIT_COUNT_W-1:0] COUNT_ZERO = 8'h00;

  typedef struct packed {
    logic [FRAME_LIMIT_BITS-1:0] bits;
    logic [BIT_COUNT_W-1:0] count;
  } card_frame_s;

  // indicator leds, one per exit, door and external tamper contact
  typedef struct packed {
    logic exit_req;
    logic aux_exit;
    logic door_closed;
    logic ext_tamper;
  } contact_leds_s;

  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_WAIT_VERDICT
  } access_state_e;

endpackage : door_access_pkg

// ---- hw/door_access_controller.sv ----
// door access controller: card reader front end, lock timing, door and tamper monitor
// Overview of operation
// - reader sends card bits on two data lines; frames up to 127 bits
// - card-present input is optional; when enabled a frame needs it seen
// - a read card number is handed to the server for checking first
// - accepted card pulses the open-collector reader led low and unlocks
// - lock output on energises the lock and lights its indicator
// - valid card releases lock for lock period, then re-energises regardless
// - closed exit input releases at once; lock period hold after reopening
// - exits release directly; post-release hold only while master is online
// - closed door contact means closed; door opened while locked raises forced alarm
// - door open time after release is timed; held-open alarm past limit
// - enclosure secure from on-board or external tamper contact, closed secure
// - each exit contact, the door contact and the external tamper contact light their led while closed
`timescale 1ns/1ps
module door_access_controller #(
  parameter int INTERBIT_CYCLES = door_access_pkg::INTERBIT_TIMEOUT_CYCLES,
  parameter int LED_CYCLES = door_access_pkg::LED_PULSE_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic wiegand_d0_n_i,
  input wire logic wiegand_d1_n_i,
  input wire logic card_present_in_i,
  input wire logic card_present_en_i,
  input wire logic exit_request_in_i,
  input wire logic aux_exit_in_i,
  input wire logic door_contact_in_i,
  input wire logic external_tamper_in_i,
  input wire logic onboard_tamper_i,
  input wire logic tamper_src_ext_i,
  input wire logic forced_alarm_en_i,
  input wire logic master_online_i,
  input wire logic [door_access_pkg::TIMER_W-1:0] lock_period_i,
  input wire logic [door_access_pkg::TIMER_W-1:0] held_open_limit_i,
  input wire logic verdict_valid_i,
  input wire logic verdict_accept_i,
  input wire logic alarm_clear_i,
  output logic card_req_o,
  output door_access_pkg::card_frame_s card_frame_o,
  output logic access_granted_o,
  output logic reader_led_o,
  output logic reader_led_oe_o,
  output logic lock_drive_out_o,
  output logic lock_led_o,
  output door_access_pkg::contact_leds_s contact_leds_o,
  output logic forced_alarm_o,
  output logic held_open_alarm_o,
  output logic enclosure_secure_o
);

  localparam logic [door_access_pkg::TIMER_W-1:0] GAP_LAST =
    door_access_pkg::TIMER_W'(INTERBIT_CYCLES - 1);
  localparam logic [door_access_pkg::TIMER_W-1:0] LED_LOAD =
    door_access_pkg::TIMER_W'(LED_CYCLES);
  localparam logic [door_access_pkg::BIT_COUNT_W-1:0] COUNT_MAX =
    door_access_pkg::BIT_COUNT_W'(door_access_pkg::FRAME_MAX_BITS);

  logic [door_access_pkg::PIN_COUNT-1:0] pins_raw, meta_q, sync_q;

  assign pins_raw = {onboard_tamper_i, external_tamper_in_i, door_contact_in_i, aux_exit_in_i,
                     exit_request_in_i, card_present_in_i, wiegand_d1_n_i, wiegand_d0_n_i};

  genvar gi;
  generate
    for (gi = 0; gi < door_access_pkg::PIN_COUNT; gi++) begin : g_sync
      always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
          meta_q[gi] <= door_access_pkg::PIN_RESET_VAL[gi];
          sync_q[gi] <= door_access_pkg::PIN_RESET_VAL[gi];
        end else begin
          meta_q[gi] <= pins_raw[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  logic d0_n, d1_n, exit_active, door_closed;
  assign d0_n = sync_q[door_access_pkg::PIN_D0];
  assign d1_n = sync_q[door_access_pkg::PIN_D1];
  // either exit contact releases the lock
  assign exit_active = sync_q[door_access_pkg::PIN_EXIT] | sync_q[door_access_pkg::PIN_AUX];
  assign door_closed = sync_q[door_access_pkg::PIN_DOOR];

  logic d0_prev_q, d1_prev_q, bit_zero, bit_one, bit_strobe;
  logic frame_active_q, frame_done_q, card_seen_q;
  logic [door_access_pkg::TIMER_W-1:0] gap_cnt_q;
  logic [door_access_pkg::FRAME_LIMIT_BITS-1:0] shift_q;
  logic [door_access_pkg::BIT_COUNT_W-1:0] count_q;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      d0_prev_q <= 1'b1;
      d1_prev_q <= 1'b1;
    end else begin
      d0_prev_q <= d0_n;
      d1_prev_q <= d1_n;
    end
  end

  // a falling edge on a line is one bit; both low at once is noise
  assign bit_zero = d0_prev_q & ~d0_n & d1_n;
  assign bit_one = d1_prev_q & ~d1_n & d0_n;
  assign bit_strobe = bit_zero | bit_one;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      frame_active_q <= 1'b0;
      frame_done_q <= 1'b0;
      gap_cnt_q <= door_access_pkg::TIMER_ZERO;
    end else begin
      frame_done_q <= 1'b0;
      if (bit_strobe) begin
        frame_active_q <= 1'b1;
        gap_cnt_q <= door_access_pkg::TIMER_ZERO;
      end else if (frame_active_q) begin
        if (gap_cnt_q >= GAP_LAST) begin
          frame_active_q <= 1'b0;
          frame_done_q <= 1'b1;
          gap_cnt_q <= door_access_pkg::TIMER_ZERO;
        end else begin
          gap_cnt_q <= gap_cnt_q + 1'b1;
        end
      end
    end
  end

  // new frame restarts the shifter; bits past the limit are dropped
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      shift_q <= '0;
      count_q <= door_access_pkg::COUNT_ZERO;
    end else if (bit_strobe) begin
      if (!frame_active_q) begin
        shift_q <= {{(door_access_pkg::FRAME_LIMIT_BITS-1){1'b0}}, bit_one};
        count_q <= 8'h01;
      end else if (count_q < COUNT_MAX) begin
        shift_q <= {shift_q[door_access_pkg::FRAME_LIMIT_BITS-2:0], bit_one};
        count_q <= count_q + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      card_seen_q <= 1'b0;
    end else if (bit_strobe && !frame_active_q) begin
      card_seen_q <= sync_q[door_access_pkg::PIN_CARD];
    end else if (sync_q[door_access_pkg::PIN_CARD]) begin
      card_seen_q <= 1'b1;
    end
  end

  door_access_pkg::access_state_e state_q;
  logic frame_ok, grant;

  assign frame_ok = frame_done_q && (count_q != door_access_pkg::COUNT_ZERO)
                    && (!card_present_en_i || card_seen_q);
  assign grant = (state_q == door_access_pkg::ACC_WAIT_VERDICT) && verdict_valid_i
                 && verdict_accept_i;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      state_q <= door_access_pkg::ACC_IDLE;
    end else begin
      unique case (state_q)
        door_access_pkg::ACC_IDLE: begin
          if (frame_ok && master_online_i) begin
            state_q <= door_access_pkg::ACC_WAIT_VERDICT;
          end
        end
        door_access_pkg::ACC_WAIT_VERDICT: begin
          // losing the master abandons the check; no verdict can come
          if (verdict_valid_i || !master_online_i) begin
            state_q <= door_access_pkg::ACC_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      card_req_o <= 1'b0;
      card_frame_o <= '0;
    end else begin
      card_req_o <= 1'b0;
      if (state_q == door_access_pkg::ACC_IDLE && frame_ok && master_online_i) begin
        card_req_o <= 1'b1;
        card_frame_o.bits <= shift_q;
        card_frame_o.count <= count_q;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      access_granted_o <= 1'b0;
    end else begin
      access_granted_o <= grant;
    end
  end

  // reader led, open collector pulled low
  logic [door_access_pkg::TIMER_W-1:0] led_cnt_q;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      led_cnt_q <= door_access_pkg::TIMER_ZERO;
      reader_led_o <= 1'b0;
      reader_led_oe_o <= 1'b0;
    end else begin
      reader_led_o <= 1'b0;
      if (grant) begin
        led_cnt_q <= LED_LOAD;
        reader_led_oe_o <= 1'b1;
      end else if (led_cnt_q != door_access_pkg::TIMER_ZERO) begin
        led_cnt_q <= led_cnt_q - 1'b1;
        reader_led_oe_o <= (led_cnt_q != 32'h00000001);
      end else begin
        reader_led_oe_o <= 1'b0;
      end
    end
  end

  logic exit_prev_q, exit_release_edge, lock_on_d;
  logic [door_access_pkg::TIMER_W-1:0] release_cnt_q, release_cnt_d;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      exit_prev_q <= 1'b0;
    end else begin
      exit_prev_q <= exit_active;
    end
  end

  assign exit_release_edge = exit_prev_q & ~exit_active;

  always_comb begin
    release_cnt_d = release_cnt_q;
    if (grant) begin
      release_cnt_d = lock_period_i;
    end else if (exit_release_edge && master_online_i) begin
      release_cnt_d = lock_period_i;
    end else if (release_cnt_q != door_access_pkg::TIMER_ZERO) begin
      release_cnt_d = release_cnt_q - 1'b1;
    end
    // exits act without the timer, straight off the contact
    lock_on_d = ~(exit_active | (release_cnt_d != door_access_pkg::TIMER_ZERO));
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      release_cnt_q <= door_access_pkg::TIMER_ZERO;
    end else begin
      release_cnt_q <= release_cnt_d;
    end
  end

  // fail-safe lock: held energised from reset until a release is asked
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      lock_drive_out_o <= 1'b1;
      lock_led_o <= 1'b1;
    end else begin
      lock_drive_out_o <= lock_on_d;
      lock_led_o <= lock_on_d;
    end
  end

  logic door_prev_q, door_opened, auth_open_q;
  logic [door_access_pkg::TIMER_W-1:0] open_cnt_q;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      // same level as the synced contact at reset, so no false opening follows
      door_prev_q <= door_access_pkg::PIN_RESET_VAL[door_access_pkg::PIN_DOOR];
    end else begin
      door_prev_q <= door_closed;
    end
  end

  assign door_opened = door_prev_q & ~door_closed;

  // opening while energised is forced; set beats clear
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      forced_alarm_o <= 1'b0;
    end else if (door_opened && lock_drive_out_o && forced_alarm_en_i) begin
      forced_alarm_o <= 1'b1;
    end else if (alarm_clear_i) begin
      forced_alarm_o <= 1'b0;
    end
  end

  // opening during a release is timed until the door closes again
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      auth_open_q <= 1'b0;
      open_cnt_q <= door_access_pkg::TIMER_ZERO;
    end else if (door_closed) begin
      auth_open_q <= 1'b0;
      open_cnt_q <= door_access_pkg::TIMER_ZERO;
    end else begin
      if (door_opened && !lock_drive_out_o) begin
        auth_open_q <= 1'b1;
      end
      if (auth_open_q && open_cnt_q != 32'hFFFFFFFF) begin
        open_cnt_q <= open_cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      held_open_alarm_o <= 1'b0;
    end else if (auth_open_q && !door_closed && open_cnt_q > held_open_limit_i) begin
      held_open_alarm_o <= 1'b1;
    end else if (alarm_clear_i) begin
      held_open_alarm_o <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      enclosure_secure_o <= 1'b0;
      contact_leds_o <= '0;
    end else begin
      enclosure_secure_o <= tamper_src_ext_i ? sync_q[door_access_pkg::PIN_XTAMP]
                                             : sync_q[door_access_pkg::PIN_OBTAMP];
      contact_leds_o.exit_req <= sync_q[door_access_pkg::PIN_EXIT];
      contact_leds_o.aux_exit <= sync_q[door_access_pkg::PIN_AUX];
      contact_leds_o.door_closed <= door_closed;
      contact_leds_o.ext_tamper <= sync_q[door_access_pkg::PIN_XTAMP];
    end
  end

endmodule : door_access_controller

// ---- verif/door_access_controller_asserts.sv ----
// port-level concurrent checks of the door access controller
`timescale 1ns/1ps
module door_access_controller_asserts #(
  parameter int INTERBIT_CYCLES = 50,
  parameter int LED_CYCLES = 20
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic exit_request_in_i,
  input wire logic door_contact_in_i,
  input wire logic external_tamper_in_i,
  input wire logic tamper_src_ext_i,
  input wire logic forced_alarm_en_i,
  input wire logic [door_access_pkg::TIMER_W-1:0] lock_period_i,
  input wire logic alarm_clear_i,
  input wire logic card_req_o,
  input wire door_access_pkg::card_frame_s card_frame_o,
  input wire logic access_granted_o,
  input wire logic reader_led_o,
  input wire logic reader_led_oe_o,
  input wire logic lock_drive_out_o,
  input wire logic lock_led_o,
  input wire door_access_pkg::contact_leds_s contact_leds_o,
  input wire logic forced_alarm_o,
  input wire logic held_open_alarm_o,
  input wire logic enclosure_secure_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  chk_lock_led: assert property (lock_led_o == lock_drive_out_o)
    else $error("lock led differs");
  chk_led_low_only: assert property (reader_led_oe_o |-> !reader_led_o)
    else $error("reader led driven high");
  chk_led_cause: assert property ($rose(reader_led_oe_o) |-> access_granted_o)
    else $error("reader led without grant");
  chk_grant_unlock: assert property (access_granted_o && lock_period_i != 0 |-> !lock_drive_out_o)
    else $error("grant kept lock");
  chk_frame_len: assert property (card_req_o |-> card_frame_o.count inside {[1:127]})
    else $error("frame length out of range");
  chk_frame_holds: assert property (!card_req_o |-> $stable(card_frame_o))
    else $error("frame moved without request");
  chk_exit_release: assert property (exit_request_in_i[*4] |-> !lock_drive_out_o && contact_leds_o.exit_req)
    else $error("exit did not release");
  chk_door_led: assert property (door_contact_in_i[*4] |=> contact_leds_o.door_closed)
    else $error("door led dark");
  chk_tamper_sel: assert property ((tamper_src_ext_i && external_tamper_in_i)[*4] |=> enclosure_secure_o)
    else $error("enclosure not secure");
  chk_forced_cause: assert property ($rose(forced_alarm_o) |-> $past(forced_alarm_en_i) && $past(lock_drive_out_o))
    else $error("forced alarm without cause");
  chk_forced_sticky: assert property (forced_alarm_o && !alarm_clear_i |=> forced_alarm_o)
    else $error("forced alarm dropped");
  chk_held_sticky: assert property (held_open_alarm_o && !alarm_clear_i |=> held_open_alarm_o)
    else $error("held alarm dropped");
endmodule : door_access_controller_asserts

// ---- verif/wiegand_reader_model.sv ----
// card reader model: pulled-up data lines and a card-present level
`timescale 1ns/1ps
module wiegand_reader_model (
  input wire logic clk_i,
  output logic d0_n_o,
  output logic d1_n_o,
  output logic card_o
);
  initial begin
    d0_n_o = 1'b1;
    d1_n_o = 1'b1;
    card_o = 1'b0;
  end
  // first bit first; 2 cycles low, 3 idle so the sync sees a gap
  task automatic send(input logic [127:0] bits, input int n, input logic cp);
    card_o = cp;
    for (int i = n - 1; i >= 0; i--) begin
      if (bits[i]) d1_n_o = 1'b0;
      else d0_n_o = 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
      d0_n_o = 1'b1;
      d1_n_o = 1'b1;
      repeat (3) @(posedge clk_i);
      #1;
    end
  endtask : send
endmodule : wiegand_reader_model

// ---- verif/door_access_controller_tb.sv ----
// self-checking bench of the door access controller
`timescale 1ns/1ps
module door_access_controller_tb;
  localparam int IBC = 50;
  localparam int LEDC = 20;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic wiegand_d0_n_i, wiegand_d1_n_i, card_present_in_i;
  logic card_present_en_i = 1'b0, exit_request_in_i = 1'b0, aux_exit_in_i = 1'b0;
  logic door_contact_in_i = 1'b1, external_tamper_in_i = 1'b1, onboard_tamper_i = 1'b0;
  logic tamper_src_ext_i = 1'b1, forced_alarm_en_i = 1'b1, master_online_i = 1'b1;
  logic verdict_valid_i = 1'b0, verdict_accept_i = 1'b0, alarm_clear_i = 1'b0;
  logic [31:0] lock_period_i = 32'h0000001E, held_open_limit_i = 32'h0000000A;
  logic card_req_o, access_granted_o, reader_led_o, reader_led_oe_o, lock_drive_out_o;
  logic lock_led_o, forced_alarm_o, held_open_alarm_o, enclosure_secure_o, got;
  door_access_pkg::card_frame_s card_frame_o;
  door_access_pkg::contact_leds_s contact_leds_o;
  int n_mismatch = 0;
  int total_checks = 0;
  int n;

  always #2 ref_clk_i = ~ref_clk_i;

  door_access_controller #(.INTERBIT_CYCLES(IBC), .LED_CYCLES(LEDC)) dut (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .wiegand_d0_n_i(wiegand_d0_n_i),
    .wiegand_d1_n_i(wiegand_d1_n_i), .card_present_in_i(card_present_in_i),
    .card_present_en_i(card_present_en_i), .exit_request_in_i(exit_request_in_i),
    .aux_exit_in_i(aux_exit_in_i), .door_contact_in_i(door_contact_in_i),
    .external_tamper_in_i(external_tamper_in_i), .onboard_tamper_i(onboard_tamper_i),
    .tamper_src_ext_i(tamper_src_ext_i), .forced_alarm_en_i(forced_alarm_en_i),
    .master_online_i(master_online_i), .lock_period_i(lock_period_i),
    .held_open_limit_i(held_open_limit_i), .verdict_valid_i(verdict_valid_i),
    .verdict_accept_i(verdict_accept_i), .alarm_clear_i(alarm_clear_i),
    .card_req_o(card_req_o), .card_frame_o(card_frame_o),
    .access_granted_o(access_granted_o), .reader_led_o(reader_led_o),
    .reader_led_oe_o(reader_led_oe_o), .lock_drive_out_o(lock_drive_out_o),
    .lock_led_o(lock_led_o), .contact_leds_o(contact_leds_o),
    .forced_alarm_o(forced_alarm_o), .held_open_alarm_o(held_open_alarm_o),
    .enclosure_secure_o(enclosure_secure_o));
  wiegand_reader_model rdr (.clk_i(ref_clk_i), .d0_n_o(wiegand_d0_n_i),
    .d1_n_o(wiegand_d1_n_i), .card_o(card_present_in_i));

  task automatic ck(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : ck

  task automatic tally_and_finish;
    if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk_i);
    #1;
  endtask : cyc

  task automatic wait_req(input int lim, input logic must);
    got = 1'b0;
    for (int i = 0; i < lim && !got; i++) begin
      cyc(1);
      got = (card_req_o === 1'b1);
    end
    if (must && !got) begin
      ck(1'b0, "no card request");
      tally_and_finish;
    end
  endtask : wait_req

  task automatic verdict(input logic acc);
    verdict_valid_i = 1'b1;
    verdict_accept_i = acc;
    cyc(1);
    verdict_valid_i = 1'b0;
  endtask : verdict

  task automatic lock_low_len;
    for (n = 0; n < 100 && lock_drive_out_o !== 1'b1; n++) cyc(1);
  endtask : lock_low_len

  task automatic t_tamper;
    for (int i = 0; i < 4; i++) begin
      {tamper_src_ext_i, external_tamper_in_i} = i[1:0];
      onboard_tamper_i = ~i[0];
      cyc(4);
      ck(enclosure_secure_o === (i[1] ? i[0] : ~i[0]), "tamper select");
      ck(contact_leds_o.ext_tamper === i[0], "tamper led");
    end
  endtask : t_tamper

  task automatic t_forced;
    ck(contact_leds_o.door_closed === 1'b1, "door led");
    door_contact_in_i = 1'b0;
    cyc(5);
    ck(forced_alarm_o === 1'b1 && contact_leds_o.door_closed === 1'b0, "forced");
    alarm_clear_i = 1'b1;
    cyc(1);
    alarm_clear_i = 1'b0;
    door_contact_in_i = 1'b1;
    forced_alarm_en_i = 1'b0;
    cyc(4);
    ck(forced_alarm_o === 1'b0, "forced clear");
    door_contact_in_i = 1'b0;
    cyc(5);
    ck(forced_alarm_o === 1'b0, "forced disabled");
    door_contact_in_i = 1'b1;
    forced_alarm_en_i = 1'b1;
    cyc(4);
  endtask : t_forced

  task automatic t_exit;
    lock_period_i = 32'h00000014;
    exit_request_in_i = 1'b1;
    cyc(4);
    ck(lock_drive_out_o === 1'b0 && contact_leds_o.exit_req === 1'b1, "exit");
    exit_request_in_i = 1'b0;
    lock_low_len;
    ck(n == 23, "exit hold");
    master_online_i = 1'b0;
    aux_exit_in_i = 1'b1;
    cyc(4);
    ck(lock_drive_out_o === 1'b0 && contact_leds_o.aux_exit === 1'b1, "aux");
    aux_exit_in_i = 1'b0;
    cyc(5);
    ck(lock_drive_out_o === 1'b1, "offline hold");
    master_online_i = 1'b1;
  endtask : t_exit

  // door left open across the relock: no forced alarm, held-open fires
  task automatic t_grant;
    lock_period_i = 32'h0000001E;
    rdr.send(128'h395A5C3, 26, 1'b1);
    wait_req(400, 1'b1);
    ck(card_frame_o.count === 8'h1A, "count");
    ck(card_frame_o.bits === 128'h395A5C3, "bits");
    verdict(1'b1);
    ck(access_granted_o === 1'b1 && reader_led_oe_o === 1'b1, "grant");
    ck(reader_led_o === 1'b0, "reader led level");
    door_contact_in_i = 1'b0;
    lock_low_len;
    ck(n === 30, "lock period");
    ck(lock_led_o === 1'b1 && forced_alarm_o === 1'b0, "relock");
    ck(held_open_alarm_o === 1'b1 && reader_led_oe_o === 1'b0, "held open");
    door_contact_in_i = 1'b1;
    // clear once the synced door reads closed; a set in the same cycle wins
    cyc(4);
    alarm_clear_i = 1'b1;
    cyc(1);
    alarm_clear_i = 1'b0;
    ck(held_open_alarm_o === 1'b0, "held clear");
  endtask : t_grant

  task automatic t_long;
    rdr.send({4{32'hA5C30F96}}, 128, 1'b1);
    wait_req(1000, 1'b1);
    ck(card_frame_o.count === 8'h7F, "saturate");
    ck(card_frame_o.bits === ({4{32'hA5C30F96}} >> 1), "last bit dropped");
    verdict(1'b0);
    ck(access_granted_o === 1'b0 && lock_drive_out_o === 1'b1, "reject");
  endtask : t_long

  task automatic t_present;
    card_present_en_i = 1'b1;
    rdr.send(128'h5, 3, 1'b0);
    wait_req(100, 1'b0);
    ck(got === 1'b0, "card absent");
    rdr.send(128'h5, 3, 1'b1);
    wait_req(100, 1'b1);
    ck(card_frame_o.count === 8'h03 && card_frame_o.bits === 128'h5, "card seen");
    verdict(1'b0);
    card_present_en_i = 1'b0;
  endtask : t_present

  initial begin
    cyc(12);
    resetn_i = 1'b1;
    cyc(1);
    ck(lock_drive_out_o === 1'b1 && card_req_o === 1'b0, "reset");
    ck(forced_alarm_o === 1'b0 && held_open_alarm_o === 1'b0, "reset alarms");
    t_tamper;
    t_forced;
    t_exit;
    t_grant;
    t_long;
    t_present;
    tally_and_finish;
  end
endmodule : door_access_controller_tb

bind door_access_controller door_access_controller_asserts #(
  .INTERBIT_CYCLES(INTERBIT_CYCLES), .LED_CYCLES(LED_CYCLES)) u_chk (
  .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .exit_request_in_i(exit_request_in_i),
  .door_contact_in_i(door_contact_in_i), .external_tamper_in_i(external_tamper_in_i),
  .tamper_src_ext_i(tamper_src_ext_i), .forced_alarm_en_i(forced_alarm_en_i),
  .lock_period_i(lock_period_i), .alarm_clear_i(alarm_clear_i), .card_req_o(card_req_o),
  .card_frame_o(card_frame_o), .access_granted_o(access_granted_o),
  .reader_led_o(reader_led_o), .reader_led_oe_o(reader_led_oe_o),
  .lock_drive_out_o(lock_drive_out_o), .lock_led_o(lock_led_o),
  .contact_leds_o(contact_leds_o), .forced_alarm_o(forced_alarm_o),
  .held_open_alarm_o(held_open_alarm_o), .enclosure_secure_o(enclosure_secure_o));
